/* core/rtc_status_consts.svh */
// Offsets, bit positions, reset values and sizes of the clock status block
`ifndef RTC_STATUS_CONSTS_SVH
`define RTC_STATUS_CONSTS_SVH
`define OFS_EVENT_STATUS 32'h0FFFFEC8
`define OFS_STATUS_CLEAR 32'hFFFFFECC
`define OFS_IRQ_ENABLE 32'hFFFFFED0
`define OFS_IRQ_DISABLE 32'hFFFFFED4
`define OFS_IRQ_MASK 32'hFFFFFED8
`define OFS_ENTRY_VALIDITY 32'hFFFFFEDC
`define OFS_EVENT_SELECT 32'hFFFFFEE0
`define BIT_UPDATE_ACK 0
`define BIT_ALARM 1
`define BIT_SECOND 2
`define BIT_TIME_EVENT 3
`define BIT_CAL_EVENT 4
`define BIT_BAD_TIME 0
`define BIT_BAD_CAL 1
`define BIT_BAD_TIME_ALARM 2
`define BIT_BAD_CAL_ALARM 3
`define TSEL_LSB 0
`define TSEL_MSB 1
`define CSEL_LSB 4
`define CSEL_MSB 5
`define FLAG_COUNT 5
`define VALID_COUNT 4
`define SYNC_COUNT 14
`define RST_STATUS 5'h00
`define RST_MASK 5'h00
`define RST_VALID 4'h0
`define RST_SELECT 2'h0
`define RST_WORD 32'h00000000
`endif

/* core/rtc_status_pkg.sv */
// Types shared by the clock status block
package rtc_status_pkg;
    typedef enum logic [1:0] {
        TSEL_MINUTE,
        TSEL_HOUR,
        TSEL_MIDNIGHT,
        TSEL_NOON
    } time_sel_t;
    typedef enum logic [1:0] {
        CSEL_WEEK,
        CSEL_MONTH,
        CSEL_YEAR,
        CSEL_NONE
    } cal_sel_t;
    typedef logic [4:0] flags_t;
    typedef logic [3:0] valid_t;
endpackage : rtc_status_pkg

/* core/rtc_status_irq.sv */
// Status flags, interrupt mask and entry validity of the calendar clock
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_status_consts.svh"

module rtc_status_irq (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [31:0] address,
    input wire logic [31:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [31:0] readData,
    output logic interrupt,
    input wire logic updateAckEvent,
    input wire logic alarmMatch,
    input wire logic secondTick,
    input wire logic minuteTick,
    input wire logic hourTick,
    input wire logic midnightTick,
    input wire logic noonTick,
    input wire logic weekTick,
    input wire logic monthTick,
    input wire logic yearTick,
    input wire logic badTimeValue,
    input wire logic badCalendarValue,
    input wire logic badTimeAlarmValue,
    input wire logic badCalendarAlarmValue
);

    function automatic logic hitAt(input logic [31:0] a, input logic [31:0] o);
        hitAt = (a == o);
    endfunction : hitAt

    // Slow-domain inputs: two flops to settle, a third for edge detection
    logic [`SYNC_COUNT-1:0] rawIn;
    logic [`SYNC_COUNT-1:0] sync1_q;
    logic [`SYNC_COUNT-1:0] sync2_q;
    logic [`SYNC_COUNT-1:0] sync3_q;
    logic [`SYNC_COUNT-1:0] rise;

    assign rawIn = {badCalendarAlarmValue, badTimeAlarmValue, badCalendarValue,
                    badTimeValue, yearTick, monthTick, weekTick, noonTick,
                    midnightTick, hourTick, minuteTick, secondTick, alarmMatch,
                    updateAckEvent};

    genvar g;
    generate
        for (g = 0; g < `SYNC_COUNT; g++) begin : gSync
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    sync1_q[g] <= 1'h0;
                    sync2_q[g] <= 1'h0;
                    sync3_q[g] <= 1'h0;
                end else begin
                    sync1_q[g] <= rawIn[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                end
            end
        end
    endgenerate

    // Slow pulses span many fast cycles, so only the rising edge counts
    assign rise = sync2_q & ~sync3_q;

    logic writeClear;
    logic writeEnable;
    logic writeDisable;
    logic writeSelect;

    assign writeClear = writeStrobe && hitAt(address, `OFS_STATUS_CLEAR);
    assign writeEnable = writeStrobe && hitAt(address, `OFS_IRQ_ENABLE);
    assign writeDisable = writeStrobe && hitAt(address, `OFS_IRQ_DISABLE);
    assign writeSelect = writeStrobe && hitAt(address, `OFS_EVENT_SELECT);

    // Event selection
    rtc_status_pkg::time_sel_t timeSel_q;
    rtc_status_pkg::cal_sel_t calSel_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timeSel_q <= rtc_status_pkg::time_sel_t'(`RST_SELECT);
            calSel_q <= rtc_status_pkg::cal_sel_t'(`RST_SELECT);
        end else if (writeSelect) begin
            timeSel_q <= rtc_status_pkg::time_sel_t'(writeData[`TSEL_MSB:`TSEL_LSB]);
            calSel_q <= rtc_status_pkg::cal_sel_t'(writeData[`CSEL_MSB:`CSEL_LSB]);
        end
    end

    logic timeEvent;
    logic calEvent;

    always_comb begin
        case (timeSel_q)
            rtc_status_pkg::TSEL_MINUTE: timeEvent = rise[3];
            rtc_status_pkg::TSEL_HOUR: timeEvent = rise[4];
            rtc_status_pkg::TSEL_MIDNIGHT: timeEvent = rise[5];
            rtc_status_pkg::TSEL_NOON: timeEvent = rise[6];
            default: timeEvent = 1'h0;
        endcase
    end

    always_comb begin
        case (calSel_q)
            rtc_status_pkg::CSEL_WEEK: calEvent = rise[7];
            rtc_status_pkg::CSEL_MONTH: calEvent = rise[8];
            rtc_status_pkg::CSEL_YEAR: calEvent = rise[9];
            default: calEvent = 1'h0;
        endcase
    end

    rtc_status_pkg::flags_t eventHit;
    rtc_status_pkg::flags_t clearBits;
    rtc_status_pkg::flags_t status_d;
    rtc_status_pkg::flags_t status_q;

    always_comb begin
        eventHit = `RST_STATUS;
        eventHit[`BIT_UPDATE_ACK] = rise[0];
        eventHit[`BIT_ALARM] = rise[1];
        eventHit[`BIT_SECOND] = rise[2];
        eventHit[`BIT_TIME_EVENT] = timeEvent;
        eventHit[`BIT_CAL_EVENT] = calEvent;
    end

    assign clearBits = writeClear ? writeData[`FLAG_COUNT-1:0] : `RST_STATUS;
    // A new event in the clearing cycle wins, so no event is lost
    assign status_d = (status_q & ~clearBits) | eventHit;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= `RST_STATUS;
        end else begin
            status_q <= status_d;
        end
    end

    // Enable and disable live at different offsets and never collide
    rtc_status_pkg::flags_t mask_d;
    rtc_status_pkg::flags_t mask_q;

    always_comb begin
        mask_d = mask_q;
        if (writeEnable) begin
            mask_d = mask_q | writeData[`FLAG_COUNT-1:0];
        end
        if (writeDisable) begin
            mask_d = mask_q & ~writeData[`FLAG_COUNT-1:0];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= `RST_MASK;
        end else begin
            mask_q <= mask_d;
        end
    end

    // Validity follows the counter block's checks of each stored entry
    rtc_status_pkg::valid_t valid_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            valid_q <= `RST_VALID;
        end else begin
            valid_q <= sync2_q[`SYNC_COUNT-1:`SYNC_COUNT-`VALID_COUNT];
        end
    end

    // Interrupt taken from next values so it tracks the flops exactly
    logic irq_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'h0;
        end else begin
            irq_q <= |(status_d & mask_d);
        end
    end

    assign interrupt = irq_q;

    logic [31:0] readD;
    logic [31:0] readData_q;

    always_comb begin
        readD = `RST_WORD;
        if (readStrobe) begin
            case (address)
                `OFS_EVENT_STATUS: readD[`FLAG_COUNT-1:0] = status_q;
                `OFS_IRQ_MASK: readD[`FLAG_COUNT-1:0] = mask_q;
                `OFS_ENTRY_VALIDITY: readD[`VALID_COUNT-1:0] = valid_q;
                `OFS_EVENT_SELECT: begin
                    readD[`TSEL_MSB:`TSEL_LSB] = timeSel_q;
                    readD[`CSEL_MSB:`CSEL_LSB] = calSel_q;
                end
                default: readD = `RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            readData_q <= `RST_WORD;
        end else begin
            readData_q <= readD;
        end
    end

    assign readData = readData_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    a_alarm_sets_flag: assert property (
        rise[1] |=> status_q[`BIT_ALARM]
    ) else $error("alarm edge did not set flag");

    a_second_set_wins: assert property (
        (rise[2] && writeClear && writeData[`BIT_SECOND])
        |=> status_q[`BIT_SECOND]
    ) else $error("second event lost against clear");

    a_time_sticky: assert property (
        (status_q[`BIT_TIME_EVENT] && !clearBits[`BIT_TIME_EVENT])
        |=> status_q[`BIT_TIME_EVENT]
    ) else $error("time flag dropped without clear");

    a_midnight_select: assert property (
        (timeSel_q == rtc_status_pkg::TSEL_MIDNIGHT && rise[5])
        |=> status_q[`BIT_TIME_EVENT]
    ) else $error("midnight select missed event");

    a_hour_ignored: assert property (
        (timeSel_q == rtc_status_pkg::TSEL_NOON && !rise[6]
         && !status_q[`BIT_TIME_EVENT] && rise[4])
        |=> !status_q[`BIT_TIME_EVENT]
    ) else $error("unselected time source set flag");

    a_year_select: assert property (
        (calSel_q == rtc_status_pkg::CSEL_YEAR && rise[9])
        |=> status_q[`BIT_CAL_EVENT]
    ) else $error("year select missed event");

    a_clear_works: assert property (
        (writeClear && writeData[`BIT_ALARM] && !rise[1])
        |=> !status_q[`BIT_ALARM]
    ) else $error("alarm flag not cleared");

    a_clear_zero_keeps: assert property (
        (writeClear && writeData[`FLAG_COUNT-1:0] == `RST_STATUS
         && eventHit == `RST_STATUS)
        |=> status_q == $past(status_q)
    ) else $error("clear with zero changed flags");

    a_enable_sets: assert property (
        (writeEnable && writeData[`BIT_UPDATE_ACK])
        |=> mask_q[`BIT_UPDATE_ACK]
    ) else $error("enable did not set mask");

    a_disable_clears: assert property (
        (writeDisable && writeData[`BIT_CAL_EVENT])
        |=> !mask_q[`BIT_CAL_EVENT]
    ) else $error("disable did not clear mask");

    a_mask_readonly: assert property (
        (writeStrobe && hitAt(address, `OFS_IRQ_MASK))
        |=> $stable(mask_q)
    ) else $error("write to mask register changed it");

    a_irq_level: assert property (
        interrupt == |(status_q & mask_q)
    ) else $error("interrupt disagrees with flags and mask");

    a_mask_read: assert property (
        (readStrobe && hitAt(address, `OFS_IRQ_MASK))
        |=> readData == {27'h0000000, $past(mask_q)}
    ) else $error("mask read wrong");

    a_wo_reads_zero: assert property (
        (readStrobe && hitAt(address, `OFS_STATUS_CLEAR))
        |=> readData == `RST_WORD
    ) else $error("write-only register read nonzero");

    a_data_one_cycle: assert property (
        !readStrobe |=> readData == `RST_WORD
    ) else $error("read data outside its cycle");

    a_valid_follows: assert property (
        $rose(sync2_q[12]) |=> valid_q[`BIT_BAD_TIME_ALARM]
    ) else $error("bad time alarm not reported");

    a_ack_sets_flag: assert property (
        rise[0] |=> status_q[`BIT_UPDATE_ACK]
    ) else $error("update acknowledge edge did not set flag");

    a_second_sets: assert property (
        rise[2] |=> status_q[`BIT_SECOND]
    ) else $error("second tick did not set flag");

    a_cal_sticky: assert property (
        (status_q[`BIT_CAL_EVENT] && !clearBits[`BIT_CAL_EVENT])
        |=> status_q[`BIT_CAL_EVENT]
    ) else $error("calendar flag dropped without clear");

    a_week_select: assert property (
        (calSel_q == rtc_status_pkg::CSEL_WEEK && rise[7])
        |=> status_q[`BIT_CAL_EVENT]
    ) else $error("week select missed event");

    a_month_ignored: assert property (
        (calSel_q == rtc_status_pkg::CSEL_YEAR && !rise[9]
         && !status_q[`BIT_CAL_EVENT] && rise[8])
        |=> !status_q[`BIT_CAL_EVENT]
    ) else $error("unselected calendar source set flag");

    a_noon_select: assert property (
        (timeSel_q == rtc_status_pkg::TSEL_NOON && rise[6])
        |=> status_q[`BIT_TIME_EVENT]
    ) else $error("noon select missed event");

    a_enable_keeps: assert property (
        (writeEnable && !writeData[`BIT_ALARM])
        |=> $stable(mask_q[`BIT_ALARM])
    ) else $error("enable changed an unwritten mask bit");

    a_disable_keeps: assert property (
        (writeDisable && !writeData[`BIT_SECOND])
        |=> $stable(mask_q[`BIT_SECOND])
    ) else $error("disable changed an unwritten mask bit");

    a_status_read: assert property (
        (readStrobe && hitAt(address, `OFS_EVENT_STATUS))
        |=> readData == {27'h0000000, $past(status_q)}
    ) else $error("status read wrong");

    a_valid_read: assert property (
        (readStrobe && hitAt(address, `OFS_ENTRY_VALIDITY))
        |=> readData == {28'h0000000, $past(valid_q)}
    ) else $error("validity read wrong");

    a_status_readonly: assert property (
        (writeStrobe && hitAt(address, `OFS_EVENT_STATUS)
         && eventHit == `RST_STATUS)
        |=> $stable(status_q)
    ) else $error("write to status register changed it");

    c_alarm_irq: cover property (
        mask_q[`BIT_ALARM] && rise[1] ##1 interrupt
    );
    c_clear_collision: cover property (
        writeClear && writeData[`BIT_SECOND] && rise[2]
    );
    c_time_event: cover property (
        timeSel_q == rtc_status_pkg::TSEL_HOUR && rise[4]
    );
    c_ack_then_clear: cover property (
        status_q[`BIT_UPDATE_ACK] ##[1:20] !status_q[`BIT_UPDATE_ACK]
    );
    c_year_event: cover property (
        calSel_q == rtc_status_pkg::CSEL_YEAR && rise[9]
    );

endmodule : rtc_status_irq
`default_nettype wire

/* verification/rtc_status_irq_bench.sv */
// Self-checking bench for the clock status and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "rtc_status_consts.svh"
module rtc_status_irq_bench;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [31:0] address = 32'h0;
    logic [31:0] writeData = 32'h0;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic [31:0] readData;
    logic interrupt;
    // Event order: ack, alarm, second, minute, hour, midnight, noon, week, month, year
    logic [9:0] evt = 10'h000;
    logic [3:0] bad = 4'h0;
    int nErrors = 0;
    int cmpCount = 0;

    always #5 clock = ~clock;

    rtc_status_irq rtc_status_irq_i (
        .clock(clock),
        .arst_n(arst_n),
        .address(address),
        .writeData(writeData),
        .writeStrobe(writeStrobe),
        .readStrobe(readStrobe),
        .readData(readData),
        .interrupt(interrupt),
        .updateAckEvent(evt[0]),
        .alarmMatch(evt[1]),
        .secondTick(evt[2]),
        .minuteTick(evt[3]),
        .hourTick(evt[4]),
        .midnightTick(evt[5]),
        .noonTick(evt[6]),
        .weekTick(evt[7]),
        .monthTick(evt[8]),
        .yearTick(evt[9]),
        .badTimeValue(bad[0]),
        .badCalendarValue(bad[1]),
        .badTimeAlarmValue(bad[2]),
        .badCalendarAlarmValue(bad[3])
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        writeStrobe <= 1'b1;
        address <= a;
        writeData <= d;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clock);
        readStrobe <= 1'b1;
        address <= a;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1;
        chk(readData, exp);
    endtask : rd

    task automatic irq(input logic exp);
        @(posedge clock);
        #1;
        chk({31'h0, interrupt}, {31'h0, exp});
    endtask : irq

    // Event levels stay three clocks high and five clocks low to pass the synchronisers
    task automatic pulse(input int i);
        @(posedge clock);
        evt[i] <= 1'b1;
        repeat (3) @(posedge clock);
        evt[i] <= 1'b0;
        repeat (5) @(posedge clock);
    endtask : pulse

    task automatic finishTest;
        $display("Comparisons %0d, mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finishTest

    initial begin
        #200000;
        nErrors++;
        finishTest();
    end

    initial begin
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`OFS_EVENT_STATUS, 32'h0);
        rd(`OFS_IRQ_MASK, 32'h0);
        rd(`OFS_ENTRY_VALIDITY, 32'h0);
        rd(`OFS_STATUS_CLEAR, 32'h0);
        rd(`OFS_IRQ_ENABLE, 32'h0);
        rd(`OFS_IRQ_DISABLE, 32'h0);
        rd(32'h00000010, 32'h0);
        wr(`OFS_IRQ_ENABLE, 32'h0000001F);
        rd(`OFS_IRQ_MASK, 32'h0000001F);
        wr(`OFS_IRQ_DISABLE, 32'h0000000A);
        rd(`OFS_IRQ_MASK, 32'h00000015);
        wr(`OFS_IRQ_MASK, 32'h00000000);
        rd(`OFS_IRQ_MASK, 32'h00000015);
        irq(1'b0);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
        end
        rd(`OFS_EVENT_STATUS, 32'h00000007);
        irq(1'b1);
        wr(`OFS_IRQ_DISABLE, 32'h00000005);
        irq(1'b0);
        wr(`OFS_IRQ_ENABLE, 32'h00000002);
        irq(1'b1);
        wr(`OFS_STATUS_CLEAR, 32'h00000002);
        irq(1'b0);
        rd(`OFS_EVENT_STATUS, 32'h00000005);
        wr(`OFS_EVENT_STATUS, 32'h00000000);
        rd(`OFS_EVENT_STATUS, 32'h00000005);
        wr(`OFS_STATUS_CLEAR, 32'h0000001F);
        rd(`OFS_EVENT_STATUS, 32'h0);
        pulse(2);
        pulse(2);
        rd(`OFS_EVENT_STATUS, 32'h00000004);
        wr(`OFS_STATUS_CLEAR, 32'h00000000);
        rd(`OFS_EVENT_STATUS, 32'h00000004);
        wr(`OFS_STATUS_CLEAR, 32'h0000001F);
        // A second tick landing on the clearing write must survive it
        @(posedge clock);
        evt[2] <= 1'b1;
        @(posedge clock);
        wr(`OFS_STATUS_CLEAR, 32'h00000004);
        evt[2] <= 1'b0;
        repeat (5) @(posedge clock);
        rd(`OFS_EVENT_STATUS, 32'h00000004);
        wr(`OFS_STATUS_CLEAR, 32'h0000001F);
        // Only the chosen tick may set the time flag
        for (int s = 0; s < 4; s++) begin
            wr(`OFS_EVENT_SELECT, 32'(s));
            for (int k = 0; k < 4; k++) begin
                pulse(3 + k);
                rd(`OFS_EVENT_STATUS, (k == s) ? 32'h00000008 : 32'h0);
                wr(`OFS_STATUS_CLEAR, 32'h0000001F);
            end
        end
        // Code three selects no calendar source at all
        for (int s = 0; s < 4; s++) begin
            wr(`OFS_EVENT_SELECT, 32'(s) << 4);
            for (int k = 0; k < 3; k++) begin
                pulse(7 + k);
                rd(`OFS_EVENT_STATUS, (k == s) ? 32'h00000010 : 32'h0);
                wr(`OFS_STATUS_CLEAR, 32'h0000001F);
            end
        end
        wr(`OFS_IRQ_ENABLE, 32'h00000018);
        pulse(3);
        irq(1'b1);
        wr(`OFS_STATUS_CLEAR, 32'h00000008);
        irq(1'b0);
        wr(`OFS_IRQ_DISABLE, 32'h00000010);
        rd(`OFS_IRQ_MASK, 32'h0000000A);
        @(posedge clock);
        bad <= 4'h3;
        repeat (5) @(posedge clock);
        rd(`OFS_ENTRY_VALIDITY, 32'h00000003);
        @(posedge clock);
        bad <= 4'hC;
        repeat (5) @(posedge clock);
        rd(`OFS_ENTRY_VALIDITY, 32'h0000000C);
        @(posedge clock);
        bad <= 4'h8;
        repeat (5) @(posedge clock);
        rd(`OFS_ENTRY_VALIDITY, 32'h00000008);
        wr(`OFS_ENTRY_VALIDITY, 32'h00000000);
        rd(`OFS_ENTRY_VALIDITY, 32'h00000008);
        // Reset in mid-run must drop the mask and the interrupt
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        rd(`OFS_IRQ_MASK, 32'h00000000);
        irq(1'b0);
        finishTest();
    end
endmodule : rtc_status_irq_bench
`default_nettype wire
